/* File: shared/spx_pkg.sv */
// Constants shared by the pixel input and general output pin block.
package spx_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] REG_CTRL_OFS    = 4'h0;
    localparam logic [3:0] REG_GPO_CFG_OFS = 4'h4;
    localparam logic [3:0] REG_STATUS_OFS  = 4'h8;
    localparam logic [3:0] REG_PIXEL_OFS   = 4'hc;

    // Control register fields.
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;

    // Output pin configuration fields.
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_VAL_LSB = 4;

    // Status register fields.
    localparam int STAT_LINE_VIOL_BIT  = 0;
    localparam int STAT_FRAME_VIOL_BIT = 1;
    localparam int STAT_STRAP_OSC_BIT  = 2;
    localparam int STAT_POWERED_BIT    = 3;
    localparam int STAT_OSC_CNT_LSB    = 8;

    // Payload modes.
    localparam logic [1:0] MODE_10B    = 2'h0;
    localparam logic [1:0] MODE_12B_HF = 2'h1;
    localparam logic [1:0] MODE_12B_LF = 2'h2;

    // Values after reset or power-down.
    localparam logic       EDGE_RST     = 1'h0;
    localparam logic [1:0] MODE_RST     = MODE_10B;
    localparam logic [3:0] SEL_LOCAL_RST = 4'hf;
    localparam logic [3:0] VAL_RST      = 4'h0;

    // Least spacing of sync transitions in 10-bit mode, in pixel clocks.
    localparam logic [3:0] SYNC_GAP_CYC = 4'ha;

    // Half period of the oscillator clock output, in system clocks.
    localparam logic [1:0] OSC_HALF_CYC = 2'h2;

    // Width of the pin synchroniser bundle.
    localparam int PIN_SYNC_W = 18;
endpackage : spx_pkg

/* File: logic/spx_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module spx_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Pins in and synchronised levels out.
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } spx_sync_st_t;

    spx_sync_st_t state_reg;
    spx_sync_st_t state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = pin_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_sync = state_reg.stage2;
endmodule : spx_sync
`default_nettype wire

/* File: logic/spx_sync_guard.sv */
// Watches one sync input for transitions spaced closer than the allowed gap.
`timescale 1ns/100ps
`default_nettype none
module spx_sync_guard
    import spx_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic sys_rst,
    // Sampled sync level and its pixel clock tick.
    input  wire logic pix_tick,
    input  wire logic sync_level,
    input  wire logic check_en,
    // Flag control.
    input  wire logic hold_clear,
    input  wire logic flag_clear,
    output logic      viol_flag
);
    typedef struct packed {
        logic       prev;
        logic [3:0] since;
        logic       viol;
    } spx_guard_st_t;

    spx_guard_st_t state_reg;
    spx_guard_st_t state_next;

    always_comb begin
        state_next = state_reg;
        if (flag_clear) begin
            state_next.viol = 1'b0;
        end
        if (pix_tick) begin
            state_next.prev = sync_level;
            if (sync_level != state_reg.prev) begin
                // A set in the same cycle as a flag_clear wins; hold_clear wins over the set.
                if (check_en && state_reg.since < SYNC_GAP_CYC - 4'h1) begin
                    state_next.viol = 1'b1;
                end
                state_next.since = 4'h0;
            end else if (state_reg.since != SYNC_GAP_CYC) begin
                state_next.since = state_reg.since + 4'h1;
            end
        end
        if (hold_clear) begin
            state_next = '{prev: 1'b0, since: SYNC_GAP_CYC, viol: 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '{prev: 1'b0, since: SYNC_GAP_CYC, viol: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign viol_flag = state_reg.viol;
endmodule : spx_sync_guard
`default_nettype wire

/* File: logic/spx_pixel_io.sv */
// Pixel input capture and general output pin routing with its register slave.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module spx_pixel_io
    import spx_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM register slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Parallel pixel pins from the image source.
    input  wire logic        pix_clk,
    input  wire logic [11:0] pix_data_in,
    input  wire logic        line_sync,
    input  wire logic        frame_sync,
    // Device control pins.
    input  wire logic        power_down_n,
    input  wire logic        osc_mode_strap,
    // Captured pixel stream towards the serial encoder.
    output logic      [11:0] pix_word,
    output logic             pix_line_sync,
    output logic             pix_frame_sync,
    output logic             pix_valid,
    // Remote input levels from the back channel, same clock.
    input  wire logic [3:0]  remote_gpio,
    // General output pins; pin 3 is two-way.
    output logic      [3:0]  general_output_pin,
    input  wire logic        general_output_pin3_in,
    output logic             general_output_pin3_oe_n
);
    typedef struct packed {
        logic        edge_sel;
        logic [1:0]  pay_mode;
        logic [3:0]  use_local;
        logic [3:0]  local_val;
        logic        strap_osc;
        logic        strap_done;
        logic        pclk_prev;
        logic        osc_in_prev;
        logic [7:0]  osc_edges;
        logic [1:0]  div_cnt;
        logic        osc_out;
        logic [11:0] pix_word;
        logic        line_sync;
        logic        frame_sync;
        logic        pix_valid;
        logic [3:0]  pin_out;
        logic        pin3_oe_n;
        logic        wait_n;
        logic [31:0] rdata;
    } spx_st_t;

    localparam spx_st_t ST_RST = '{
        edge_sel:    EDGE_RST,
        pay_mode:    MODE_RST,
        use_local:   SEL_LOCAL_RST,
        local_val:   VAL_RST,
        strap_osc:   1'b0,
        strap_done:  1'b0,
        pclk_prev:   1'b0,
        osc_in_prev: 1'b0,
        osc_edges:   8'h00,
        div_cnt:     2'h0,
        osc_out:     1'b0,
        pix_word:    12'h000,
        line_sync:   1'b0,
        frame_sync:  1'b0,
        pix_valid:   1'b0,
        pin_out:     4'h0,
        pin3_oe_n:   1'b0,
        wait_n:      1'b0,
        rdata:       32'h0000_0000
    };

    spx_st_t state_reg;
    spx_st_t state_next;

    // Every pin from outside passes the same two flops, so data, syncs and
    // the pixel clock keep their relative timing after synchronisation.
    logic [PIN_SYNC_W-1:0] pins_sync;
    logic        pclk_s;
    logic [11:0] data_s;
    logic        ls_s;
    logic        fs_s;
    logic        pdn_s;
    logic        strap_s;
    logic        osc_in_s;

    spx_sync #(
        .W(PIN_SYNC_W)
    ) u_pin_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pin_in   ({pix_clk, pix_data_in, line_sync, frame_sync,
                    power_down_n, osc_mode_strap, general_output_pin3_in}),
        .pin_sync (pins_sync)
    );

    assign {pclk_s, data_s, ls_s, fs_s, pdn_s, strap_s, osc_in_s} = pins_sync;

    // Pixel clock edge detection on the synchronised level.
    logic pclk_rise;
    logic pclk_fall;
    logic pix_tick;
    logic ten_bit;

    assign pclk_rise = pclk_s & ~state_reg.pclk_prev;
    assign pclk_fall = ~pclk_s & state_reg.pclk_prev;
    assign pix_tick  = pdn_s & (state_reg.edge_sel ? pclk_fall : pclk_rise);
    assign ten_bit   = (state_reg.pay_mode == MODE_10B);

    // Bus handshake decode.
    logic bus_req;
    logic bus_take;
    logic wr_lane0;
    logic line_clr;
    logic frame_clr;
    logic line_viol;
    logic frame_viol;

    assign bus_req   = avs_read | avs_write;
    assign bus_take  = bus_req & state_reg.wait_n;
    assign wr_lane0  = avs_write & bus_take & avs_byteenable[0];
    assign line_clr  = wr_lane0 & (avs_address == REG_STATUS_OFS)
                       & avs_writedata[STAT_LINE_VIOL_BIT];
    assign frame_clr = wr_lane0 & (avs_address == REG_STATUS_OFS)
                       & avs_writedata[STAT_FRAME_VIOL_BIT];

    // In 12-bit modes the guards stay disarmed; the guards only flag, so the syncs go through raw in every mode.
    spx_sync_guard u_line_guard (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .pix_tick   (pix_tick),
        .sync_level (ls_s),
        .check_en   (ten_bit),
        .hold_clear (~pdn_s),
        .flag_clear (line_clr),
        .viol_flag  (line_viol)
    );

    spx_sync_guard u_frame_guard (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .pix_tick   (pix_tick),
        .sync_level (fs_s),
        .check_en   (ten_bit),
        .hold_clear (~pdn_s),
        .flag_clear (frame_clr),
        .viol_flag  (frame_viol)
    );

    // Pin source selection for one pin: register bit or remote level.
    function automatic logic pin_src(input logic sel_local, input logic loc,
                                     input logic remote);
        pin_src = sel_local ? loc : remote;
    endfunction : pin_src

    always_comb begin
        state_next           = state_reg;
        state_next.pclk_prev = pclk_s;
        state_next.pix_valid = 1'b0;

        // Strap is taken once after reset or power-up, then held.
        if (!state_reg.strap_done) begin
            state_next.strap_osc  = strap_s;
            state_next.strap_done = 1'b1;
        end

        // Pixel capture.
        if (pix_tick) begin
            if (ten_bit) begin
                state_next.pix_word = {2'b00, data_s[9:0]};
            end else begin
                state_next.pix_word = data_s;
            end
            // Syncs are forwarded as sampled on each pixel clock.
            state_next.line_sync  = ls_s;
            state_next.frame_sync = fs_s;
            state_next.pix_valid  = 1'b1;
        end

        // Oscillator clock output divider runs only in oscillator mode.
        if (state_reg.strap_osc) begin
            if (state_reg.div_cnt == OSC_HALF_CYC - 2'h1) begin
                state_next.div_cnt = 2'h0;
                state_next.osc_out = ~state_reg.osc_out;
            end else begin
                state_next.div_cnt = state_reg.div_cnt + 2'h1;
            end
        end else begin
            state_next.div_cnt = 2'h0;
            state_next.osc_out = 1'b0;
        end

        // Count oscillator clock rising edges seen on the clock input pin.
        state_next.osc_in_prev = osc_in_s;
        if (state_reg.strap_osc && osc_in_s && !state_reg.osc_in_prev) begin
            state_next.osc_edges = state_reg.osc_edges + 8'h01;
        end

        // Output pin routing.
        for (int i = 0; i < 2; i++) begin
            state_next.pin_out[i] = pin_src(state_reg.use_local[i],
                                            state_reg.local_val[i], remote_gpio[i]);
        end
        if (state_reg.strap_osc) begin
            state_next.pin_out[2] = state_reg.osc_out;
            state_next.pin_out[3] = 1'b0;
            state_next.pin3_oe_n  = 1'b1;
        end else begin
            state_next.pin_out[2] = pin_src(state_reg.use_local[2],
                                            state_reg.local_val[2], remote_gpio[2]);
            state_next.pin_out[3] = pin_src(state_reg.use_local[3],
                                            state_reg.local_val[3], remote_gpio[3]);
            state_next.pin3_oe_n  = 1'b0;
        end

        // Register writes take effect on the edge after the wait, while waitrequest is low.
        if (wr_lane0) begin
            case (avs_address)
                REG_CTRL_OFS: begin
                    state_next.edge_sel = avs_writedata[CTRL_EDGE_BIT];
                    state_next.pay_mode = avs_writedata[CTRL_MODE_LSB +: 2];
                end
                REG_GPO_CFG_OFS: begin
                    state_next.use_local = avs_writedata[CFG_SEL_LSB +: 4];
                    state_next.local_val = avs_writedata[CFG_VAL_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // One wait cycle per access; read data is loaded with it so it is
        // steady at the edge where the master samples it.
        state_next.wait_n = bus_req & ~state_reg.wait_n;
        if (bus_req && !state_reg.wait_n) begin
            state_next.rdata = 32'h0000_0000;
            if (avs_read) begin
                case (avs_address)
                    REG_CTRL_OFS: begin
                        state_next.rdata[CTRL_EDGE_BIT]      = state_reg.edge_sel;
                        state_next.rdata[CTRL_MODE_LSB +: 2] = state_reg.pay_mode;
                    end
                    REG_GPO_CFG_OFS: begin
                        state_next.rdata[CFG_SEL_LSB +: 4] = state_reg.use_local;
                        state_next.rdata[CFG_VAL_LSB +: 4] = state_reg.local_val;
                    end
                    REG_STATUS_OFS: begin
                        state_next.rdata[STAT_LINE_VIOL_BIT]  = line_viol;
                        state_next.rdata[STAT_FRAME_VIOL_BIT] = frame_viol;
                        state_next.rdata[STAT_STRAP_OSC_BIT]  = state_reg.strap_osc;
                        state_next.rdata[STAT_POWERED_BIT]    = pdn_s;
                        state_next.rdata[STAT_OSC_CNT_LSB +: 8] = state_reg.osc_edges;
                    end
                    REG_PIXEL_OFS: begin
                        state_next.rdata[11:0] = state_reg.pix_word;
                        state_next.rdata[12]   = state_reg.line_sync;
                        state_next.rdata[13]   = state_reg.frame_sync;
                    end
                    default: begin
                        state_next.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Power-down drops all control state and drives the pins low; the bus
        // keeps answering so software can see the powered bit.
        if (!pdn_s) begin
            state_next        = ST_RST;
            state_next.wait_n = bus_req & ~state_reg.wait_n;
            state_next.rdata  = state_reg.rdata;
            if (bus_req && !state_reg.wait_n) begin
                state_next.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata             = state_reg.rdata;
    assign avs_waitrequest          = ~state_reg.wait_n;
    assign pix_word                 = state_reg.pix_word;
    assign pix_line_sync            = state_reg.line_sync;
    assign pix_frame_sync           = state_reg.frame_sync;
    assign pix_valid                = state_reg.pix_valid;
    assign general_output_pin       = state_reg.pin_out;
    assign general_output_pin3_oe_n = state_reg.pin3_oe_n;
endmodule : spx_pixel_io
`default_nettype wire

/* File: sim/spx_pixel_io_sva.sv */
// Port-level checker for the pixel input and output pin block.
`timescale 1ns/100ps
`default_nettype none
module spx_pixel_io_chk
    import spx_pkg::*;
(
    // Clock, reset and register bus.
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    // Pixel side.
    input wire logic        pix_clk,
    input wire logic        power_down_n,
    input wire logic [11:0] pix_word,
    input wire logic        pix_valid,
    // Output pins.
    input wire logic [3:0]  remote_gpio,
    input wire logic [3:0]  general_output_pin,
    input wire logic        general_output_pin3_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       edge_q, hit, wr_ok;
    logic [1:0] mode_q;
    logic [7:0] cfg_q, hist;
    logic [2:0] up_cnt;
    logic [3:0] want;
    always_comb begin
        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
        hit = 1'b0;
        // Half the pixel period is four clocks, so a wrong-edge capture falls outside the window.
        for (int j = 2; j < 6; j++)
            if (hist[j] != hist[j+1] && hist[j] == !edge_q) hit = 1'b1;
        want = (cfg_q[3:0] & cfg_q[7:4]) | (~cfg_q[3:0] & remote_gpio);
    end
    // The shadow clears at the raw pin, so pin checks rest until the design has settled again.
    always_ff @(posedge clk) begin
        hist <= {hist[6:0], pix_clk};
        if (sys_rst || !power_down_n) begin
            edge_q <= EDGE_RST;
            mode_q <= MODE_RST;
            cfg_q <= {VAL_RST, SEL_LOCAL_RST};
            up_cnt <= 3'h0;
        end else begin
            if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
            if (wr_ok && avs_address == REG_CTRL_OFS) begin
                edge_q <= avs_writedata[CTRL_EDGE_BIT];
                mode_q <= avs_writedata[CTRL_MODE_LSB +: 2];
            end
            if (wr_ok && avs_address == REG_GPO_CFG_OFS) cfg_q <= avs_writedata[7:0];
        end
    end
    chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_valid_pulse: assert property (pix_valid |=> !pix_valid)
        else $error("pixel valid longer than one cycle");
    chk_valid_edge: assert property (pix_valid |-> hit)
        else $error("pixel taken off the selected clock edge");
    chk_ten_bit: assert property (pix_valid && mode_q == MODE_10B |-> pix_word[11:10] == 2'h0)
        else $error("upper pixel bits pass in ten-bit mode");
    chk_pin_follow: assert property (up_cnt == 3'h7 |-> general_output_pin[1:0] == $past(want[1:0]))
        else $error("low output pins do not follow their source");
    chk_pd_pins: assert property (!power_down_n [*5] |-> general_output_pin == 4'h0 && !pix_valid)
        else $error("pins or capture active in power-down");
    chk_pin3_free: assert property (general_output_pin3_oe_n |-> general_output_pin[3] == 1'b0)
        else $error("released pin three still driven high");
    chk_osc_clock: assert property (general_output_pin3_oe_n && up_cnt == 3'h7 && $changed(general_output_pin[2])
        |=> $stable(general_output_pin[2]) ##1 $changed(general_output_pin[2]))
        else $error("oscillator clock output not toggling every two cycles");
    cov_fall_pixel: cover property (pix_valid && edge_q);
    cov_hf_pixel: cover property (pix_valid && mode_q == MODE_12B_HF);
    cov_osc: cover property (general_output_pin3_oe_n);
    cov_pd: cover property (!power_down_n [*5]);
endmodule : spx_pixel_io_chk
bind spx_pixel_io spx_pixel_io_chk u_chk (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .pix_clk, .power_down_n, .pix_word,
    .pix_valid, .remote_gpio, .general_output_pin, .general_output_pin3_oe_n);
`default_nettype wire

/* File: sim/spx_sensor_model.sv */
// Behavioural image source driving the parallel pixel pins.
`timescale 1ns/100ps
`default_nettype none
module spx_sensor_model (
    // Parallel pixel pins.
    output var logic        pix_clk,
    output var logic [11:0] pix_data_in,
    output var logic        line_sync,
    output var logic        frame_sync
);
    initial begin
        pix_clk = 1'b0;
        pix_data_in = 12'h000;
        line_sync = 1'b0;
        frame_sync = 1'b0;
    end
    task automatic put_px(input int i, input logic [11:0] base, input int gap);
        pix_data_in = base + 12'(i) * 12'h0a5;
        line_sync = ((i / gap) % 2) == 1;
        frame_sync = ((i / (2 * gap)) % 2) == 1;
    endtask : put_px
    // Data changes on the idle edge, four system clocks away from the sampling edge.
    task automatic send_frame(input int n, input logic [11:0] base, input int gap, input logic fall);
        #10;
        for (int i = 0; i < n; i++) begin
            if (!fall) put_px(i, base, gap);
            #200 pix_clk = 1'b1;
            if (fall) put_px(i, base, gap);
            #200 pix_clk = 1'b0;
        end
        // The clock stands low between frames and the pulled-down pins fall back to zero.
        #200 put_px(0, 12'h000, 1);
    endtask : send_frame
endmodule : spx_sensor_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the pixel input and output pin block.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import spx_pkg::*;
;
    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, pix_clk, line_sync;
    logic        frame_sync, power_down_n, osc_mode_strap, pix_line_sync, pix_frame_sync;
    logic        pix_valid, general_output_pin3_in, general_output_pin3_oe_n;
    logic [3:0]  avs_address, avs_byteenable, remote_gpio, general_output_pin;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [11:0] pix_data_in, pix_word;
    int          fail_count, check_count;
    spx_pixel_io u_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .pix_clk, .pix_data_in, .line_sync,
        .frame_sync, .power_down_n, .osc_mode_strap, .pix_word, .pix_line_sync, .pix_frame_sync,
        .pix_valid, .remote_gpio, .general_output_pin, .general_output_pin3_in,
        .general_output_pin3_oe_n);
    spx_sensor_model u_src (.pix_clk, .pix_data_in, .line_sync, .frame_sync);
    always #25 clk = ~clk;
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : expect_eq
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            expect_eq(32'h0, 32'h1, "bus answer timeout");
            complete_run();
        end
    endtask : bus_xfer
    task automatic do_reset(input logic strap);
        osc_mode_strap <= strap;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : do_reset
    task automatic frame_check(input logic [1:0] mode, input logic fall, input int gap);
        logic [11:0] w;
        int idx;
        idx = 0;
        bus_xfer(1'b1, REG_CTRL_OFS, {29'h0, mode, fall});
        fork
            u_src.send_frame(24, 12'hc3a, gap, fall);
            for (int n = 0; n < 300; n++) begin
                @(posedge clk);
                if (pix_valid === 1'b1) begin
                    w = 12'hc3a + 12'(idx) * 12'h0a5;
                    if (mode == MODE_10B) w[11:10] = 2'h0;
                    expect_eq({pix_frame_sync, pix_line_sync, pix_word},
                        {1'((idx / (2 * gap)) % 2), 1'((idx / gap) % 2), w}, "pixel");
                    idx++;
                end
            end
        join
        expect_eq(idx, 24, "pixel count");
        bus_xfer(1'b0, REG_PIXEL_OFS, 32'h0);
        expect_eq(rd[11:0], w, "pixel register");
    endtask : frame_check
    task automatic scen_reset();
        expect_eq({general_output_pin, general_output_pin3_oe_n, pix_valid}, 6'h0, "idle");
        bus_xfer(1'b0, REG_CTRL_OFS, 32'h0);
        expect_eq(rd, 32'h0, "ctrl default");
        bus_xfer(1'b0, REG_GPO_CFG_OFS, 32'h0);
        expect_eq(rd, 32'h0f, "pin config default");
        bus_xfer(1'b1, 4'h2, 32'hff);
        bus_xfer(1'b0, 4'h2, 32'h0);
        expect_eq(rd, 32'h0, "unmapped read");
        bus_xfer(1'b0, REG_STATUS_OFS, 32'h0);
        expect_eq(rd[15:0], 16'h0008, "status after reset");
    endtask : scen_reset
    task automatic scen_ten_bit();
        frame_check(MODE_10B, 1'b0, 10);
        bus_xfer(1'b0, REG_STATUS_OFS, 32'h0);
        expect_eq(rd[1:0], 2'h0, "no spacing flag at gap ten");
        frame_check(MODE_10B, 1'b0, 9);
        bus_xfer(1'b0, REG_STATUS_OFS, 32'h0);
        expect_eq(rd[1:0], 2'h3, "spacing flags at gap nine");
        bus_xfer(1'b1, REG_STATUS_OFS, 32'h3);
        bus_xfer(1'b0, REG_STATUS_OFS, 32'h0);
        expect_eq(rd[1:0], 2'h0, "spacing flags cleared");
    endtask : scen_ten_bit
    task automatic scen_twelve();
        frame_check(MODE_12B_HF, 1'b1, 1);
        frame_check(MODE_12B_LF, 1'b0, 2);
    endtask : scen_twelve
    task automatic scen_gpo();
        logic [7:0] cfg [4] = '{8'haf, 8'h35, 8'h00, 8'hca};
        logic [3:0] r;
        for (int i = 0; i < 4; i++) begin
            r = 4'h6 ^ 4'(i);
            remote_gpio <= r;
            bus_xfer(1'b1, REG_GPO_CFG_OFS, {24'h0, cfg[i]});
            repeat (3) @(posedge clk);
            expect_eq(general_output_pin, (cfg[i][3:0] & cfg[i][7:4]) | (~cfg[i][3:0] & r), "pins");
        end
        bus_xfer(1'b0, REG_GPO_CFG_OFS, 32'h0);
        expect_eq(rd, 32'hca, "pin config readback");
    endtask : scen_gpo
    task automatic scen_power_down();
        bus_xfer(1'b1, REG_CTRL_OFS, 32'h5);
        bus_xfer(1'b1, REG_GPO_CFG_OFS, 32'hff);
        power_down_n <= 1'b0;
        repeat (8) @(posedge clk);
        expect_eq(general_output_pin, 4'h0, "pins in power-down");
        power_down_n <= 1'b1;
        repeat (8) @(posedge clk);
        bus_xfer(1'b0, REG_CTRL_OFS, 32'h0);
        expect_eq(rd, 32'h0, "ctrl after power-down");
        bus_xfer(1'b0, REG_GPO_CFG_OFS, 32'h0);
        expect_eq(rd, 32'h0f, "pin config after power-down");
    endtask : scen_power_down
    task automatic scen_osc();
        int edges;
        logic last;
        do_reset(1'b1);
        repeat (6) @(posedge clk);
        expect_eq({general_output_pin[3], general_output_pin3_oe_n}, 2'h1, "pin three free");
        edges = 0;
        last = general_output_pin[2];
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (general_output_pin[2] !== last) edges++;
            last = general_output_pin[2];
        end
        expect_eq(edges, 20, "oscillator output toggles");
        repeat (5) begin
            general_output_pin3_in <= 1'b1;
            repeat (4) @(posedge clk);
            general_output_pin3_in <= 1'b0;
            repeat (4) @(posedge clk);
        end
        bus_xfer(1'b0, REG_STATUS_OFS, 32'h0);
        expect_eq({rd[15:8], rd[2]}, 9'h00b, "oscillator input edges and strap");
    endtask : scen_osc
    initial begin
        clk = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {remote_gpio, general_output_pin3_in, osc_mode_strap, fail_count, check_count} = '0;
        avs_byteenable = 4'h1;
        power_down_n = 1'b1;
        sys_rst = 1'b1;
        do_reset(1'b0);
        scen_reset();
        scen_ten_bit();
        scen_twelve();
        scen_gpo();
        scen_power_down();
        scen_osc();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
